/* File: design/tws_pkg.sv */
// shared constants and types for the two-wire slave transmitter
// assumes a 100 MHz pclk and an apb master with 32-bit data
package tws_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] TWS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TWS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] TWS_ADDR_DATA = 8'h08;
  localparam logic [7:0] TWS_ADDR_OWN = 8'h0c;
  localparam logic [7:0] TWS_ADDR_IRQ_ST = 8'h10;
  localparam logic [7:0] TWS_ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] TWS_ADDR_SLEEP = 8'h18;

  // ****************************************
  // status codes, low three bits always zero
  // ****************************************
  localparam logic [7:0] TWS_ST_SLA_R_ACK = 8'ha8;
  localparam logic [7:0] TWS_ST_ARB_SLA_R = 8'hb0;
  localparam logic [7:0] TWS_ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] TWS_ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] TWS_ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] TWS_ST_NO_INFO = 8'hf8;
  localparam logic [7:0] TWS_STATUS_MASK = 8'hf8;

  // ****************************************
  // reset values and bit counts
  // ****************************************
  localparam logic [7:0] TWS_CTRL_RST = 8'h00;
  localparam logic [7:0] TWS_OWN_RST = 8'h00;
  localparam logic [7:0] TWS_DATA_RST = 8'hff;
  localparam logic [6:0] TWS_GC_ADDR = 7'h00;
  localparam logic [3:0] TWS_ADDR_BITS = 4'h8;
  localparam logic [2:0] TWS_LAST_BIT = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int TWS_CLK_NS = 10;
  localparam int TWS_TSU_DAT_NS = 250;
  localparam int TWS_THD_STA_NS = 4000;
  localparam int TWS_SU_CYC = (TWS_TSU_DAT_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;
  localparam int TWS_HD_CYC = (TWS_THD_STA_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;
  localparam logic [8:0] TWS_SU_CNT = 9'(TWS_SU_CYC);
  localparam logic [8:0] TWS_HD_CNT = 9'(TWS_HD_CYC);

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic flag;      // step_complete_flag
    logic ack_en;    // ack_enable_bit
    logic start_req; // start_request_bit
    logic stop_req;  // stop_request_bit
    logic wcol;      // write collision
    logic enable;    // unit enable
    logic rsvd1;
    logic rsvd0;
  } tws_ctrl_s;

  typedef struct packed {
    logic start_done;
    logic wake;
    logic step;
  } tws_irq_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pin_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_HOLD = 3'b011,
    S_TX = 3'b100,
    S_TX_ACK = 3'b101,
    S_IGNORE = 3'b110,
    S_START = 3'b111
  } tws_state_e;

endpackage

/* File: design/tws_sync.sv */
// two-flop synchroniser for the bus pins
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module tws_sync
  import tws_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire tws_pin_s pin_in, // raw pins
  output tws_pin_s pin_sync // synchronised pins
);

  // ****************************************
  // per-pin double flop
  // ****************************************
  localparam int W = $bits(tws_pin_s);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // idle bus is high, so reset to one
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_r;

endmodule // tws_sync
`default_nettype wire

/* File: design/tws_slave_tx.sv */
// two-wire slave transmitter with apb register access
// assumes pclk at 100 MHz, open-drain bus pins resolved outside
//
// Contract
// R01: in sleep, own address still matched and acked from bus clock if ack enabled
// R02: after sleep match, wake the part and hold SCL low until flag cleared
// R03: after flag cleared following wake, transfer continues normally
// R04: long wake-up keeps SCL low and blocks other bus users
// R05: data register is not updated by bus traffic during sleep
// R06: 0xA8 own address read acked; ack enable picks last or ordinary byte
// R07: 0xB0 arbitration lost then own read address acked; same load choices
// R08: 0xB8 byte acked by master; ack enable picks next byte kind
// R09: 0xC0 byte got not-ack; go not addressed per start and ack bits
// R10: 0xC8 last byte still acked; go not addressed per start and ack bits
// R11: not addressed with ack enabled sees own address, general call only if enabled
// R12: start request on 0xC0/0xC8 sends START once bus is free
// R13: own read address received sets flag and valid status
// R14: own address register holds 7-bit address high, general call enable low
// R15: after final byte, further reads ignored with SDA released
// R16: software writes stop request zero and one to flag to proceed
// R17: software masks prescaler bits of status before comparing
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tx
  import tws_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic scl_in, // serial clock pin level
  output logic scl_out, // serial clock drive value
  output logic scl_oe, // serial clock pull low
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe, // serial data pull low
  input wire logic arb_lost_in, // master unit lost arbitration in address
  output logic wake_out, // wake request to power control
  output logic irq_out // level interrupt
);

  // ****************************************
  // register decode helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, TWS_ADDR_CTRL) | hit(a, TWS_ADDR_STATUS) | hit(a, TWS_ADDR_DATA) |
             hit(a, TWS_ADDR_OWN) | hit(a, TWS_ADDR_IRQ_ST) | hit(a, TWS_ADDR_IRQ_MASK) |
             hit(a, TWS_ADDR_SLEEP);
  endfunction

  tws_ctrl_s ctrl_r;
  tws_irq_s irq_st_r;
  tws_irq_s irq_mask_r;
  tws_state_e state_r;
  tws_pin_s pin_raw;
  tws_pin_s pin_s;
  logic [7:0] data_r;
  logic [7:0] own_r;
  logic [7:0] status_r;
  logic [7:0] addr_sh_r;
  logic [7:0] tx_sh_r;
  logic [3:0] bit_cnt_r;
  logic [8:0] wait_r;
  logic scl_d_r, sda_d_r;
  logic sleep_r, busy_r, last_r, ack_seen_r, hold_tx_r, loaded_r;
  logic set_flag, wake_evt, start_evt;
  logic acc, wr, wr_ctrl, wr_data;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic own_match, gc_match, addr_match;

  // ****************************************
  // apb slave
  // ****************************************
  // transfer completes in the second access cycle, when pready is seen high
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign wr_ctrl = wr & hit(paddr, TWS_ADDR_CTRL);
  assign wr_data = wr & hit(paddr, TWS_ADDR_DATA);

  // one wait state keeps read data and ready both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      prdata <= 32'h0000_0000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          TWS_ADDR_CTRL: prdata[7:0] <= ctrl_r;
          // R17 status bits
          TWS_ADDR_STATUS: prdata[7:0] <= ctrl_r.flag ? (status_r & TWS_STATUS_MASK)
                                                       : TWS_ST_NO_INFO;
          TWS_ADDR_DATA: prdata[7:0] <= data_r;
          TWS_ADDR_OWN: prdata[7:0] <= own_r;
          TWS_ADDR_IRQ_ST: prdata[2:0] <= irq_st_r;
          TWS_ADDR_IRQ_MASK: prdata[2:0] <= irq_mask_r;
          TWS_ADDR_SLEEP: prdata[0] <= sleep_r;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; hardware setting of the flag wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= TWS_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.ack_en <= pwdata[6];
        ctrl_r.start_req <= pwdata[5];
        ctrl_r.stop_req <= pwdata[4];
        ctrl_r.enable <= pwdata[2];
        // R16 one clears flag
        if (pwdata[7]) begin
          ctrl_r.flag <= 1'b0;
        end
      end
      if (wr_data) begin
        ctrl_r.wcol <= ~ctrl_r.flag;
      end
      if (start_evt) begin
        ctrl_r.start_req <= 1'b0;
      end
      if (set_flag) begin
        ctrl_r.flag <= 1'b1;
      end
    end
  end

  // R05 data only from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= TWS_DATA_RST;
    end else if (wr_data && ctrl_r.flag) begin
      data_r <= pwdata[7:0];
    end
  end

  // own address and sleep control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_r <= TWS_OWN_RST;
      sleep_r <= 1'b0;
      irq_mask_r <= '0;
    end else if (wr) begin
      if (hit(paddr, TWS_ADDR_OWN)) own_r <= pwdata[7:0];
      if (hit(paddr, TWS_ADDR_SLEEP)) sleep_r <= pwdata[0];
      if (hit(paddr, TWS_ADDR_IRQ_MASK)) irq_mask_r <= pwdata[2:0];
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr & hit(paddr, TWS_ADDR_IRQ_ST)) ? pwdata[2:0] : 3'h0))
                  | {start_evt, wake_evt, set_flag};
      irq_out <= |(irq_st_r & irq_mask_r);
    end
  end

  // ****************************************
  // bus pin sampling and conditions
  // ****************************************
  assign pin_raw = '{scl: scl_in, sda: sda_in};

  tws_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_raw),
    .pin_sync(pin_s)
  );

  // delayed copies for edge finding, read only after the second flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= pin_s.scl;
      sda_d_r <= pin_s.sda;
    end
  end

  assign scl_rise = pin_s.scl & ~scl_d_r;
  assign scl_fall = ~pin_s.scl & scl_d_r;
  assign bus_start = scl_d_r & pin_s.scl & sda_d_r & ~pin_s.sda & (state_r != S_START);
  assign bus_stop = scl_d_r & pin_s.scl & ~sda_d_r & pin_s.sda;

  // bus busy between start and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (bus_start) begin
      busy_r <= 1'b1;
    end else if (bus_stop) begin
      busy_r <= 1'b0;
    end
  end

  // R14 address layout
  assign own_match = (addr_sh_r[7:1] == own_r[7:1]);
  assign gc_match = own_r[0] & (addr_sh_r[7:1] == TWS_GC_ADDR);
  // R11 ack enable gates recognition; general call is a write, so it never reaches tx
  assign addr_match = ctrl_r.ack_en & addr_sh_r[0] & (own_match | gc_match);

  // ****************************************
  // protocol engine
  // ****************************************
  // R01 address matching runs whether or not sleep is set, off the bus clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      status_r <= TWS_ST_NO_INFO;
      addr_sh_r <= 8'h00;
      tx_sh_r <= 8'hff;
      bit_cnt_r <= 4'h0;
      wait_r <= 9'h000;
      last_r <= 1'b0;
      ack_seen_r <= 1'b0;
      hold_tx_r <= 1'b0;
      loaded_r <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      set_flag <= 1'b0;
      wake_evt <= 1'b0;
      start_evt <= 1'b0;
    end else begin
      set_flag <= 1'b0;
      wake_evt <= 1'b0;
      start_evt <= 1'b0;
      if (!ctrl_r.enable) begin
        state_r <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_r <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_r <= S_ADDR;
        bit_cnt_r <= 4'h0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            // R12 start when free
            if (ctrl_r.start_req && !busy_r && !ctrl_r.flag) begin
              state_r <= S_START;
              sda_oe <= 1'b1;
              wait_r <= TWS_HD_CNT;
            end
          end
          S_START: begin
            // hold data low past the start hold time, then hand over
            if (wait_r == 9'h000) begin
              sda_oe <= 1'b0;
              start_evt <= 1'b1;
              state_r <= S_IGNORE;
            end else begin
              wait_r <= wait_r - 9'h001;
            end
          end
          S_ADDR: begin
            if (scl_rise && bit_cnt_r != TWS_ADDR_BITS) begin
              addr_sh_r <= {addr_sh_r[6:0], pin_s.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == TWS_ADDR_BITS) begin
              if (addr_match) begin
                sda_oe <= 1'b1;
                state_r <= S_ADDR_ACK;
                // R02 wake on match
                if (sleep_r) begin
                  wake_evt <= 1'b1;
                end
              end else begin
                state_r <= S_IGNORE;
              end
            end
          end
          S_ADDR_ACK: begin
            if (scl_fall) begin
              // R13 flag and status
              sda_oe <= 1'b0;
              scl_oe <= 1'b1;
              set_flag <= 1'b1;
              hold_tx_r <= 1'b1;
              // R07 lost arbitration
              status_r <= arb_lost_in ? TWS_ST_ARB_SLA_R : TWS_ST_SLA_R_ACK;
              loaded_r <= 1'b0;
              state_r <= S_HOLD;
            end
          end
          S_HOLD: begin
            // R02 stretch until clear
            // R04 stretch has no time limit; a slow wake-up blocks the bus
            if (!ctrl_r.flag && !set_flag) begin
              if (hold_tx_r) begin
                // R03 resume transfer
                if (!loaded_r) begin
                  // R06 ack enable picks kind
                  tx_sh_r <= data_r;
                  last_r <= ~ctrl_r.ack_en;
                  sda_oe <= ~data_r[7];
                  bit_cnt_r <= 4'h0;
                  wait_r <= TWS_SU_CNT;
                  loaded_r <= 1'b1;
                end else if (wait_r == 9'h000) begin
                  scl_oe <= 1'b0;
                  state_r <= S_TX;
                end else begin
                  wait_r <= wait_r - 9'h001;
                end
              end else begin
                // R09 not addressed after nack
                // R10 not addressed after last ack
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                state_r <= S_IGNORE;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r[2:0] == TWS_LAST_BIT) begin
                sda_oe <= 1'b0;
                state_r <= S_TX_ACK;
              end else begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                sda_oe <= ~tx_sh_r[6];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              ack_seen_r <= ~pin_s.sda;
            end else if (scl_fall) begin
              scl_oe <= 1'b1;
              set_flag <= 1'b1;
              loaded_r <= 1'b0;
              state_r <= S_HOLD;
              if (!ack_seen_r) begin
                status_r <= TWS_ST_DATA_NACK;
                hold_tx_r <= 1'b0;
              end else if (last_r) begin
                status_r <= TWS_ST_LAST_ACK;
                hold_tx_r <= 1'b0;
              end else begin
                // R08 next byte
                status_r <= TWS_ST_DATA_ACK;
                hold_tx_r <= 1'b1;
              end
            end
          end
          S_IGNORE: begin
            // R15 sda released
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
          default: begin
            state_r <= S_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // wake and constant drive values
  // ****************************************
  // wake request stands until software leaves sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_out <= 1'b0;
    end else if (!sleep_r) begin
      wake_out <= 1'b0;
    end else if (wake_evt) begin
      wake_out <= 1'b1;
    end
  end

  // open drain: the pins only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule // tws_slave_tx
`default_nettype wire

/* File: sim/tws_master_model.sv */
// behavioural master receiver for the two-wire bus, 160 ns bit period
// assumes the bench resolves both wires with pull-ups from all pull enables
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
  input wire logic scl, // resolved clock wire
  input wire logic sda, // resolved data wire
  output logic scl_pull, // master pulls clock low
  output logic sda_pull, // master pulls data low
  output logic [7:0] rx_byte, // last byte read
  output int rx_cnt // bytes read so far
);
  // ****************************************
  // bus primitives
  // ****************************************
  // released wires rise through the pull-ups, so an idle bus reads high
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    rx_cnt = 0;
  end

  // one bit; a slave holding the clock low just stretches the low phase
  task automatic bit_cycle(input logic drv, output logic smp);
    sda_pull = !drv;
    #80;
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #40;
    smp = sda;
    #40;
    scl_pull = 1'b1;
  endtask

  task automatic start_cond;
    sda_pull = 1'b1;
    #80;
    scl_pull = 1'b1;
  endtask

  task automatic stop_cond;
    sda_pull = 1'b1;
    #80;
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #80;
    sda_pull = 1'b0;
    #80;
  endtask

  // address byte, most significant bit first, then the slave's answer
  task automatic send_addr(input logic [7:0] a, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(a[i], s);
    bit_cycle(1'b1, ack_n);
  endtask

  task automatic read_byte(input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(!ack, s);
    rx_byte = d;
    rx_cnt++;
  endtask
endmodule // tws_master_model
`default_nettype wire

/* File: sim/tws_slave_tx_asserts.sv */
// concurrent checks on the slave transmitter's top-level ports
// assumes a single pclk domain with async active-low reset
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tx_asserts
  import tws_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic scl_out, // clock drive value
  input wire logic scl_oe, // clock pull low
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data pull low
  input wire logic wake_out, // wake request
  input wire logic irq_out // interrupt
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mapped words only; anything else must be refused
  wire logic mapped = paddr <= TWS_ADDR_SLEEP && paddr[1:0] == 2'b00;

  ready_time_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped address refused");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  scl_hold_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
    else $error("clock hold too short");
  data_setup_a: assert property ($fell(scl_oe) |-> sda_oe == $past(sda_oe, 8))
    else $error("data changed before clock release");
  // sleep bit drops first, wake request one edge later
  wake_clear_a: assert property (pready && pwrite && paddr == TWS_ADDR_SLEEP
    && !pwdata[0] |=> ##1 !wake_out)
    else $error("wake not cleared");
  mask_off_a: assert property (pready && pwrite && paddr == TWS_ADDR_IRQ_MASK
    && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq_out)
    else $error("masked interrupt raised");
endmodule // tws_slave_tx_asserts

bind tws_slave_tx tws_slave_tx_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_out, .scl_oe, .sda_out, .sda_oe,
  .wake_out, .irq_out);
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench: apb master, bus master model, expected-value queues
// assumes the slave answers apb in its own time; a watchdog cuts hangs
`timescale 1ns/1ps
`default_nettype none
module tb
  import tws_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, arb_lost_in, an;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake_out, irq_out;
  logic m_scl, m_sda;
  logic [7:0] rx_byte;
  logic [6:0] sa;
  logic [32:0] got;
  logic [32:0] exp_q[$];
  logic [7:0] byte_q[$];
  int rx_n, err_total, checks_done, cyc;
  // open-drain wires with pull-ups
  wire logic scl_w = !(scl_oe || m_scl);
  wire logic sda_w = !(sda_oe || m_sda);

  tws_slave_tx dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out,
    .sda_oe, .arb_lost_in, .wake_out, .irq_out);
  tws_master_model mm (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda),
    .rx_byte, .rx_cnt(rx_n));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog well above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [32:0] e, input logic [32:0] g, input string m);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read results: pre-edge values are the settled ones
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      got = {pslverr, prdata};
      if (paddr == TWS_ADDR_STATUS) got[2:0] = 3'h0;
      chk(exp_q.pop_front(), got, "read");
    end
  end

  always @(rx_n) chk({25'h0, byte_q.pop_front()}, {25'h0, rx_byte}, "byte");

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 2000) chk(33'h1, 33'h0, "no interrupt");
  endtask

  // one completed step: status code, sticky bits, clock held low
  task automatic step(input logic [7:0] code, input logic [2:0] ist);
    wait_irq();
    rd(TWS_ADDR_STATUS, {25'h0, code});
    rd(TWS_ADDR_IRQ_ST, {30'h0, ist});
    chk(33'h0, {32'h0, scl_w}, "clock held");
    apb(1'b1, TWS_ADDR_IRQ_ST, 32'h7);
  endtask

  // stop request written zero, flag written one
  task automatic load(input logic [7:0] c);
    logic [7:0] d;
    d = 8'($urandom);
    byte_q.push_back(d);
    apb(1'b1, TWS_ADDR_DATA, {24'h0, d});
    apb(1'b1, TWS_ADDR_CTRL, {24'h0, c});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    arb_lost_in = 1'b0;
    void'($urandom(73));
    sa = 7'($urandom_range(8, 119));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TWS_ADDR_CTRL, 33'h0);
    rd(TWS_ADDR_STATUS, {25'h0, TWS_ST_NO_INFO});
    rd(TWS_ADDR_DATA, {25'h0, TWS_DATA_RST});
    rd(8'h1c, 33'h1_0000_0000);
    apb(1'b1, TWS_ADDR_IRQ_MASK, 32'h0);
    $display("reset test done");
    apb(1'b1, TWS_ADDR_OWN, {24'h0, sa, 1'b0});
    apb(1'b1, TWS_ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, TWS_ADDR_CTRL, 32'h44);
    mm.start_cond();
    mm.send_addr({sa, 1'b1}, an);
    chk(33'h0, {32'h0, an}, "address ack");
    step(TWS_ST_SLA_R_ACK, 3'h1);
    load(8'hc4);
    mm.read_byte(1'b1);
    step(TWS_ST_DATA_ACK, 3'h1);
    load(8'h84);
    mm.read_byte(1'b1);
    step(TWS_ST_LAST_ACK, 3'h1);
    apb(1'b1, TWS_ADDR_CTRL, 32'hc4);
    byte_q.push_back(8'hff);
    mm.read_byte(1'b0);
    mm.stop_cond();
    $display("ack path test done");
    arb_lost_in <= 1'b1;
    mm.start_cond();
    mm.send_addr({sa, 1'b1}, an);
    step(TWS_ST_ARB_SLA_R, 3'h1);
    arb_lost_in <= 1'b0;
    load(8'hc4);
    mm.read_byte(1'b0);
    step(TWS_ST_DATA_NACK, 3'h1);
    apb(1'b1, TWS_ADDR_CTRL, 32'h84);
    mm.stop_cond();
    mm.start_cond();
    mm.send_addr({sa, 1'b1}, an);
    chk(33'h1, {32'h0, an}, "address ignored");
    mm.stop_cond();
    $display("not-ack path test done");
    apb(1'b1, TWS_ADDR_SLEEP, 32'h1);
    apb(1'b1, TWS_ADDR_CTRL, 32'h44);
    arb_lost_in <= 1'($urandom);
    mm.start_cond();
    mm.send_addr({sa, 1'b1}, an);
    step(arb_lost_in ? TWS_ST_ARB_SLA_R : TWS_ST_SLA_R_ACK, 3'h3);
    chk(33'h1, {32'h0, wake_out}, "wake");
    rd(TWS_ADDR_IRQ_ST, 33'h0);
    load(8'hc4);
    mm.read_byte(1'b0);
    step(TWS_ST_DATA_NACK, 3'h1);
    apb(1'b1, TWS_ADDR_SLEEP, 32'h0);
    $display("sleep test done");
    apb(1'b1, TWS_ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, TWS_ADDR_CTRL, 32'he4);
    mm.stop_cond();
    wait_irq();
    rd(TWS_ADDR_IRQ_ST, 33'h4);
    rd(TWS_ADDR_CTRL, 33'h44);
    $display("start request test done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
